//--- bsw_regs.v
// Secondary status and memory window registers of a bridge function
`include "bsw_defs.vh"

// Notes on behaviour
// - Seen system error sets bit 14
// - Own master abort sets bit 13
// - Received target abort sets bit 12
// - Signalled target abort sets bit 11
// - Bits 10:9 read fixed 01b
// - Parity fault as master, if enabled, sets bit 8
// - Bit 7 reads one, back-to-back capable
// - Bit 5 reads one, 66 MHz capable
// - Bits 6 and 4:0 read zero
// - Memory base field gives address 31:20
// - Memory limit field gives address 31:20, ones below
// - Forward memory cycles inside window inclusive
// - Low nibble of base and limit read zero
// - Base and limit reset to zero
// - Prefetch base field gives address 31:20
// - Upper base register supplies address 63:32
// - Prefetch base low nibble reads 1, 64-bit
// - Registers at 20h, 22h, 24h, 16 bits
module bsw_regs (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Configuration access, 16-bit at even byte offsets
  input wire [7:0] cfg_addr,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [15:0] cfg_wdata,
  input wire [1:0] cfg_be,
  output reg [15:0] cfg_rdata,
  output reg cfg_hit,
  // Prefetch upper base word, held elsewhere
  input wire [31:0] pf_upper_base,
  // Bridge control bit 0
  input wire parity_response_enable,
  // Secondary bus events, one-cycle pulses
  input wire system_error_seen,
  input wire master_abort_evt,
  input wire target_abort_rx_evt,
  input wire target_abort_tx_evt,
  input wire master_is_read,
  input wire master_perr_asserted,
  input wire master_perr_detected,
  input wire master_active,
  // Upstream memory request decode
  input wire [63:0] req_addr,
  input wire req_valid,
  output reg fwd_mem,
  output reg fwd_pf
);

  // ----------------------------------------
  // Window registers
  // ----------------------------------------
  reg [11:0] window_low_bits_q;
  reg [11:0] window_high_bits_q;
  reg [11:0] prefetch_low_bits_q;
  wire [15:0] status_rd;
  wire [4:0] flags;
  wire wr_status;
  wire parity_evt;

  // Byte-enabled write to a field in bits 15:4
  function [11:0] merge_field;
    input [11:0] old_val;
    input [15:0] wdata;
    input [1:0] be;
    begin
      merge_field = old_val;
      if (be[0]) merge_field[3:0] = wdata[7:4];
      if (be[1]) merge_field[11:4] = wdata[15:8];
    end
  endfunction

  // Writable window fields, reset to zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      window_low_bits_q <= `BSW_MEM_LOW_RST;
      window_high_bits_q <= `BSW_MEM_HIGH_RST;
      prefetch_low_bits_q <= `BSW_PF_LOW_RST;
    end else if (cfg_wr) begin
      if (cfg_addr == `BSW_OFF_MEM_LOW) begin
        window_low_bits_q <= merge_field(window_low_bits_q, cfg_wdata, cfg_be);
      end
      if (cfg_addr == `BSW_OFF_MEM_HIGH) begin
        window_high_bits_q <= merge_field(window_high_bits_q, cfg_wdata, cfg_be);
      end
      if (cfg_addr == `BSW_OFF_PF_LOW) begin
        prefetch_low_bits_q <= merge_field(prefetch_low_bits_q, cfg_wdata, cfg_be);
      end
    end
  end

  // ----------------------------------------
  // Sticky status flags
  // ----------------------------------------
  assign wr_status = cfg_wr && (cfg_addr == `BSW_OFF_STATUS);
  assign parity_evt = master_active && parity_response_enable &&
    ((master_is_read && master_perr_asserted) ||
     (!master_is_read && master_perr_detected));

  bsw_flag u_system_error_seen (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_pulse(system_error_seen),
    .clr_pulse(wr_status && cfg_be[1] && cfg_wdata[`BSW_ST_SYSTEM_ERROR_SEEN]),
    .flag_q(flags[4])
  );
  bsw_flag u_master_abort_seen (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_pulse(master_abort_evt),
    .clr_pulse(wr_status && cfg_be[1] && cfg_wdata[`BSW_ST_MASTER_ABORT_SEEN]),
    .flag_q(flags[3])
  );
  bsw_flag u_ta_rec (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_pulse(target_abort_rx_evt),
    .clr_pulse(wr_status && cfg_be[1] && cfg_wdata[`BSW_ST_TA_REC]),
    .flag_q(flags[2])
  );
  bsw_flag u_ta_sig (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_pulse(target_abort_tx_evt),
    .clr_pulse(wr_status && cfg_be[1] && cfg_wdata[`BSW_ST_TA_SIG]),
    .flag_q(flags[1])
  );
  bsw_flag u_mpar (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_pulse(parity_evt),
    .clr_pulse(wr_status && cfg_be[1] && cfg_wdata[`BSW_ST_MPAR]),
    .flag_q(flags[0])
  );

  // Status image: flags plus fixed capability bits, reserved zero
  assign status_rd = `BSW_ST_FIXED |
    ({15'h0000, flags[4]} << `BSW_ST_SYSTEM_ERROR_SEEN) |
    ({15'h0000, flags[3]} << `BSW_ST_MASTER_ABORT_SEEN) |
    ({15'h0000, flags[2]} << `BSW_ST_TA_REC) |
    ({15'h0000, flags[1]} << `BSW_ST_TA_SIG) |
    ({15'h0000, flags[0]} << `BSW_ST_MPAR);

  // ----------------------------------------
  // Read data, registered one cycle after the strobe
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= 16'h0000;
      cfg_hit <= 1'b0;
    end else if (cfg_rd) begin
      cfg_hit <= 1'b1;
      case (cfg_addr)
        `BSW_OFF_STATUS: cfg_rdata <= status_rd;
        `BSW_OFF_MEM_LOW: cfg_rdata <= {window_low_bits_q, 4'h0};
        `BSW_OFF_MEM_HIGH: cfg_rdata <= {window_high_bits_q, 4'h0};
        `BSW_OFF_PF_LOW: cfg_rdata <= {prefetch_low_bits_q, `BSW_WIDE_FLAG};
        default: begin
          cfg_rdata <= 16'h0000;
          cfg_hit <= 1'b0;
        end
      endcase
    end else begin
      cfg_hit <= 1'b0;
    end
  end

  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  wire [63:0] mem_low_addr;
  wire [63:0] mem_high_addr;
  wire [63:0] pf_low_addr;
  wire mem_hit;
  wire pf_ge;

  // Base pads zeros below bit 20, limit pads ones
  assign mem_low_addr = {32'h00000000, window_low_bits_q, 20'h00000};
  assign mem_high_addr = {32'h00000000, window_high_bits_q, 20'hfffff};
  assign pf_low_addr = {pf_upper_base, prefetch_low_bits_q, 20'h00000};

  bsw_win_cmp u_mem_cmp (
    .low_addr(mem_low_addr),
    .high_addr(mem_high_addr),
    .addr(req_addr),
    .hit(mem_hit)
  );

  // Prefetch limit lives elsewhere; only the lower bound is checked here
  assign pf_ge = (req_addr >= pf_low_addr);

  // Registered forward decisions
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_mem <= 1'b0;
      fwd_pf <= 1'b0;
    end else begin
      fwd_mem <= req_valid && mem_hit;
      fwd_pf <= req_valid && pf_ge;
    end
  end

endmodule // bsw_regs

//--- bsw_defs.vh
// Offsets, field positions and reset values of the bridge window registers
`ifndef BSW_DEFS_VH
`define BSW_DEFS_VH
// ----------------------------------------
// Configuration offsets (byte addresses)
// ----------------------------------------
`define BSW_OFF_STATUS 8'h1e
`define BSW_OFF_MEM_LOW 8'h20
`define BSW_OFF_MEM_HIGH 8'h22
`define BSW_OFF_PF_LOW 8'h24
`define BSW_OFF_PF_UPPER 8'h28
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define BSW_ST_SYSTEM_ERROR_SEEN 14
`define BSW_ST_MASTER_ABORT_SEEN 13
`define BSW_ST_TA_REC 12
`define BSW_ST_TA_SIG 11
`define BSW_ST_MPAR 8
// Fixed read-only status pattern: bits 10:9 = 01b, bit 7 = 1, bit 5 = 1
`define BSW_ST_FIXED 16'h02a0
// ----------------------------------------
// Window fields and reset values
// ----------------------------------------
`define BSW_WIN_MSB 15
`define BSW_WIN_LSB 4
`define BSW_MEM_LOW_RST 12'h000
`define BSW_MEM_HIGH_RST 12'h000
`define BSW_PF_LOW_RST 12'h000
`define BSW_PF_UPPER_RST 32'h00000000
// Low nibble of the prefetch base: 64-bit capable
`define BSW_WIDE_FLAG 4'h1
`endif

//--- bsw_flag.v
// One sticky status flag: set by hardware, cleared by writing one
module bsw_flag (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Set and clear
  input wire set_pulse,
  input wire clr_pulse,
  // State
  output reg flag_q
);

  // Set wins over a same-cycle clear
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (set_pulse) begin
      flag_q <= 1'b1;
    end else if (clr_pulse) begin
      flag_q <= 1'b0;
    end
  end

endmodule // bsw_flag

//--- bsw_win_cmp.v
// Inclusive window compare on a 64-bit address
module bsw_win_cmp (
  // Window bounds
  input wire [63:0] low_addr,
  input wire [63:0] high_addr,
  // Address under test
  input wire [63:0] addr,
  // Result
  output wire hit
);

  // Inside base..limit, both ends included
  assign hit = (addr >= low_addr) && (addr <= high_addr);

endmodule // bsw_win_cmp

//--- bsw_monitor.sv
// Assertion checker for the bridge status and window registers
`include "bsw_defs.vh"
module bsw_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration side
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_hit,
  // Events and decode
  input wire logic system_error_seen,
  input wire logic master_abort_evt,
  input wire logic req_valid,
  input wire logic fwd_mem,
  input wire logic fwd_pf
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Status read in progress
  wire logic st_rd = cfg_rd && cfg_addr == `BSW_OFF_STATUS;
  hit_after_read_a: assert property (st_rd |=> cfg_hit) else $error("no hit");
  unmapped_quiet_a: assert property (cfg_rd && cfg_addr == 8'h40 |=> !cfg_hit &&
    cfg_rdata == 16'h0000) else $error("unmapped read answered");
  status_fixed_a: assert property (st_rd |=> (cfg_rdata & 16'h06ff) == `BSW_ST_FIXED)
    else $error("fixed status bits wrong");
  system_error_seen_flag_a: assert property (system_error_seen ##1 st_rd |=> cfg_rdata[14])
    else $error("system error flag missing");
  abort_flag_a: assert property (master_abort_evt ##1 st_rd |=> cfg_rdata[13])
    else $error("master abort flag missing");
  win_nibble_a: assert property (cfg_rd && (cfg_addr == 8'h20 || cfg_addr == 8'h22)
    |=> cfg_rdata[3:0] == 4'h0) else $error("window nibble not zero");
  wide_flag_a: assert property (cfg_rd && cfg_addr == 8'h24 |=> cfg_rdata[3:0] == 4'h1)
    else $error("wide address flag wrong");
  no_req_quiet_a: assert property (!req_valid |=> !fwd_mem && !fwd_pf)
    else $error("forward without request");
  cover property (st_rd ##1 cfg_hit);
  cover property (fwd_mem);
  cover property (fwd_pf);
endmodule // bsw_monitor
bind bsw_regs bsw_monitor mon_u (.ref_clk, .rstn, .cfg_addr, .cfg_rd, .cfg_rdata, .cfg_hit,
  .system_error_seen, .master_abort_evt, .req_valid, .fwd_mem, .fwd_pf);

//--- bsw_sec_agent.sv
// Model of the secondary bus agents that raise bus events
module bsw_sec_agent (
  // Clock
  input wire logic ref_clk,
  // serr, master_abort_seen, ta_rx, ta_tx, active, is_read, perr_out, perr_in
  output logic [7:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev = 8'h00;
  // Raise one event after dly idle cycles, held one cycle
  task automatic raise(input int kind, input int dly);
    logic [7:0] pat;
    case (kind)
      4: pat = 8'h70;
      5: pat = 8'h90;
      default: pat = 8'h01 << kind;
    endcase
    repeat (dly) @(negedge ref_clk);
    ev <= pat;
    @(negedge ref_clk);
    ev <= 8'h00;
  endtask
endmodule // bsw_sec_agent

//--- testbench.sv
// Self-checking bench for the bridge status and window registers
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, req_valid = 1'b0;
  logic parity_response_enable = 1'b0, cfg_hit, fwd_mem, fwd_pf;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] ev;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata;
  logic [1:0] cfg_be = 2'b00;
  logic [31:0] pf_upper_base = 32'h00000001;
  logic [63:0] req_addr = 64'h0;
  int fails = 0, checks = 0;
  bsw_regs dut_u (.ref_clk, .rstn, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_be,
    .cfg_rdata, .cfg_hit, .pf_upper_base, .parity_response_enable,
    .system_error_seen(ev[0]), .master_abort_evt(ev[1]), .target_abort_rx_evt(ev[2]),
    .target_abort_tx_evt(ev[3]), .master_active(ev[4]), .master_is_read(ev[5]),
    .master_perr_asserted(ev[6]), .master_perr_detected(ev[7]), .req_addr, .req_valid,
    .fwd_mem, .fwd_pf);
  bsw_sec_agent agent_u (.ref_clk, .ev);
  // Clock
  always #2 ref_clk = ~ref_clk;
  // ----
  // Access tasks
  // ----
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic h);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    `CHK(cfg_rdata, e)
    `CHK(cfg_hit, h)
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = b;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic fw(input logic [63:0] a, input logic [1:0] e);
    req_addr = a;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    `CHK({fwd_mem, fwd_pf}, e)
    @(negedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    rd(8'h1e, 16'h02a0, 1'b1);
    rd(8'h20, 16'h0000, 1'b1);
    rd(8'h22, 16'h0000, 1'b1);
    rd(8'h24, 16'h0001, 1'b1);
    rd(8'h40, 16'h0000, 1'b0);
    $display("test reset done");
    wr(8'h20, 16'hffff, 2'b01);
    rd(8'h20, 16'h00f0, 1'b1);
    wr(8'h20, 16'h1230, 2'b11);
    wr(8'h22, 16'h12ff, 2'b11);
    wr(8'h24, 16'h456f, 2'b11);
    wr(8'h40, 16'hffff, 2'b11);
    rd(8'h22, 16'h12f0, 1'b1);
    rd(8'h24, 16'h4561, 1'b1);
    $display("test windows done");
    fw(64'h0000_0000_122f_ffff, 2'b00);
    fw(64'h0000_0000_1230_0000, 2'b10);
    fw(64'h0000_0000_12ff_ffff, 2'b10);
    fw(64'h0000_0000_1300_0000, 2'b00);
    fw(64'h0000_0001_4560_0000, 2'b01);
    fw(64'h0000_0001_455f_ffff, 2'b00);
    fw(64'h0000_0000_4560_0000, 2'b00);
    $display("test forwarding done");
    for (int k = 0; k < 4; k++) begin
      agent_u.raise(k, k);
      rd(8'h1e, 16'h02a0 | (16'h4000 >> k), 1'b1);
      wr(8'h1e, 16'h0000, 2'b11);
      rd(8'h1e, 16'h02a0 | (16'h4000 >> k), 1'b1);
      wr(8'h1e, 16'h4000 >> k, 2'b11);
      rd(8'h1e, 16'h02a0, 1'b1);
    end
    agent_u.raise(4, 0);
    rd(8'h1e, 16'h02a0, 1'b1);
    parity_response_enable = 1'b1;
    agent_u.raise(4, 1);
    rd(8'h1e, 16'h03a0, 1'b1);
    wr(8'h1e, 16'h0100, 2'b11);
    rd(8'h1e, 16'h02a0, 1'b1);
    agent_u.raise(5, 2);
    rd(8'h1e, 16'h03a0, 1'b1);
    $display("test events done");
    report_and_stop();
  end
endmodule // testbench
